// File: core/pscp_pkg.sv
/*
 * Shared constants and carriers for the passive serial configuration port.
 * Assumes a 40 MHz core clock; the serial clock is a separate domain.
 */
package pscp_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_MHZ = 40;
    localparam int unsigned STATUS_US = 10;
    localparam int unsigned STATUS_CYC = STATUS_US * CLK_MHZ;
    localparam int unsigned INIT_US = 55;
    localparam int unsigned INIT_CYC = INIT_US * CLK_MHZ;
    localparam int unsigned POR_US = 100;
    localparam int unsigned POR_CYC = POR_US * CLK_MHZ;
    localparam int unsigned USR_INIT_CYC = 8532;
    localparam int unsigned CNT_W = 16;
    localparam logic [1:0] FALL_EDGES = 2'h2;

    // ------------------------------------------------------------
    // data layout
    // ------------------------------------------------------------
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned RUN_BIT = 7;
    localparam logic [2:0] LAST_BIT = 3'h7;

    // ------------------------------------------------------------
    // synchroniser slots
    // ------------------------------------------------------------
    localparam int unsigned SI_REQ = 0;
    localparam int unsigned SI_STAT = 1;
    localparam int unsigned SI_DONE = 2;
    localparam int unsigned SI_UCLK = 3;
    localparam int unsigned SI_CE = 4;
    localparam int unsigned SI_TGL = 5;
    localparam int unsigned SI_LOAD = 6;
    localparam int unsigned SI_FALL = 7;
    localparam int unsigned SYNC_N = 8;

    typedef enum logic [2:0] {
        ST_POR = 3'h0,
        ST_RESET = 3'h1,
        ST_LOAD = 3'h2,
        ST_RELEASE = 3'h3,
        ST_INIT = 3'h4,
        ST_USER = 3'h5,
        ST_ERROR = 3'h6
    } pscp_state_e;

    // link domain towards core domain
    typedef struct packed {
        logic [BYTE_W-1:0] data;
        logic tgl;
        logic loaded;
        logic fall_ok;
    } pscp_up_s;

    // core domain towards link domain
    typedef struct packed {
        logic load_en;
        logic done_high;
    } pscp_dn_s;

endpackage

// File: core/pscp_link.sv
/*
 * Serial-clock side of the port: shifts bits in, hands bytes over.
 * Assumes chip enable is driven in step with the serial clock upstream.
 */
`timescale 1ns/10ps
module pscp_link #(
    parameter int unsigned BYTES = 1024,
    parameter int unsigned LEN_W = 24
) (
    // serial link
    input wire logic serial_config_clock,
    input wire logic serial_config_data_in,
    input wire logic chip_enable_in_n,
    // core side
    input wire pscp_pkg::pscp_dn_s dn,
    output pscp_pkg::pscp_up_s up
);

    // ------------------------------------------------------------
    // level crossings into the serial domain
    // ------------------------------------------------------------
    logic [1:0] en_sync_r;
    logic [1:0] dh_sync_r;

    always_ff @(posedge serial_config_clock)
    begin
        en_sync_r <= {en_sync_r[0], dn.load_en};
        dh_sync_r <= {dh_sync_r[0], dn.done_high};
    end

    // ------------------------------------------------------------
    // shifter
    // ------------------------------------------------------------
    logic [pscp_pkg::BYTE_W-1:0] shift_r;
    logic [pscp_pkg::BYTE_W-1:0] byte_r;
    logic [2:0] bit_r;
    logic [LEN_W-1:0] cnt_r;
    logic loaded_r;
    logic tgl_r;
    logic take;

    // chip enable is looked at on the same edge, so a freshly enabled
    // device takes the very first bit
    assign take = en_sync_r[1] && !chip_enable_in_n && !loaded_r;

    always_ff @(posedge serial_config_clock)
    begin
        if (!en_sync_r[1])
        begin
            bit_r <= 3'h0;
            cnt_r <= '0;
            loaded_r <= 1'b0;
            tgl_r <= 1'b0;
        end
        else if (take)
        begin
            shift_r <= {serial_config_data_in, shift_r[7:1]};
            bit_r <= bit_r + 3'h1;
            if (bit_r == pscp_pkg::LAST_BIT)
            begin
                byte_r <= {serial_config_data_in, shift_r[7:1]};
                tgl_r <= ~tgl_r;
                cnt_r <= cnt_r + LEN_W'(1);
                // later clocks are ignored once the image is in
                if (cnt_r == LEN_W'(BYTES - 1))
                    loaded_r <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // falling edges after the done line rises
    // ------------------------------------------------------------
    logic [1:0] fall_r;

    always_ff @(negedge serial_config_clock)
    begin
        if (!dh_sync_r[1])
            fall_r <= 2'h0;
        else if (fall_r != pscp_pkg::FALL_EDGES)
            fall_r <= fall_r + 2'h1;
    end

    assign up.data = byte_r;
    assign up.tgl = tgl_r;
    assign up.loaded = loaded_r;
    assign up.fall_ok = (fall_r == pscp_pkg::FALL_EDGES);

endmodule

// File: core/pscp_top.sv
/*
 * Passive serial configuration port: sequencing, pins, byte pipe.
 * Assumes an external host clocks the image in and resolves the
 * open-drain lines from the enables given here.
 */
`timescale 1ns/10ps
module pscp_top #(
    parameter int unsigned BYTES = 1024,
    parameter int unsigned LEN_W = 24,
    parameter int unsigned POR_CYC = pscp_pkg::POR_CYC,
    parameter int unsigned USR_INIT_CYC = pscp_pkg::USR_INIT_CYC,
    // arbitrary neutral seed
    parameter logic [7:0] KEY = 8'h5c
) (
    // core clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // serial link
    input wire logic serial_config_clock,
    input wire logic serial_config_data_in,
    input wire logic chip_enable_in_n,
    // configuration request
    input wire logic config_request_n,
    // shared open-drain status line
    input wire logic status_open_drain_n_in,
    output logic status_open_drain_n_out,
    output logic status_open_drain_n_oe,
    // shared open-drain done line
    input wire logic config_complete_line_in,
    output logic config_complete_line_out,
    output logic config_complete_line_oe,
    // chain enable pin
    output logic chain_enable_out_n,
    output logic chain_enable_out_n_oe,
    // initialization clock
    input wire logic user_startup_clock,
    // options
    input wire logic user_clock_en,
    input wire logic decompress_en,
    input wire logic decrypt_en,
    input wire logic chain_pin_user,
    input wire logic chain_user_data,
    // image bytes and status
    output logic [7:0] config_byte,
    output logic config_byte_valid,
    output logic user_mode,
    output logic config_error
);

    // ------------------------------------------------------------
    // serial domain
    // ------------------------------------------------------------
    pscp_pkg::pscp_up_s up;
    pscp_pkg::pscp_dn_s dn;

    pscp_link #(
        .BYTES(BYTES),
        .LEN_W(LEN_W)
    ) u_link (
        .serial_config_clock(serial_config_clock),
        .serial_config_data_in(serial_config_data_in),
        .chip_enable_in_n(chip_enable_in_n),
        .dn(dn),
        .up(up)
    );

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    localparam int unsigned N = pscp_pkg::SYNC_N;

    logic [N-1:0] raw;
    logic [N-1:0] s1_r;
    logic [N-1:0] s2_r;
    logic [N-1:0] s3_r;
    logic [N-1:0] q_r;
    logic [N-1:0] qd_r;

    always_comb
    begin
        raw = '0;
        raw[pscp_pkg::SI_REQ] = config_request_n;
        raw[pscp_pkg::SI_STAT] = status_open_drain_n_in;
        raw[pscp_pkg::SI_DONE] = config_complete_line_in;
        raw[pscp_pkg::SI_UCLK] = user_startup_clock;
        raw[pscp_pkg::SI_CE] = chip_enable_in_n;
        raw[pscp_pkg::SI_TGL] = up.tgl;
        raw[pscp_pkg::SI_LOAD] = up.loaded;
        raw[pscp_pkg::SI_FALL] = up.fall_ok;
    end

    always_ff @(posedge clk)
    begin
        s1_r <= raw;
        s2_r <= s1_r;
        s3_r <= s2_r;
        qd_r <= q_r;
    end

    // a change is taken only once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < N; gi++)
        begin : g_sync
            always_ff @(posedge clk)
            begin
                if (!rst_n)
                    q_r[gi] <= 1'b1;
                else if (s2_r[gi] == s3_r[gi])
                    q_r[gi] <= s3_r[gi];
            end
        end
    endgenerate

    logic req_low;
    logic stat_low;
    logic done_high;
    logic ce_low;
    logic uclk_rise;
    logic byte_evt;
    logic loaded;
    logic fall_ok;

    assign req_low = !q_r[pscp_pkg::SI_REQ];
    assign stat_low = !q_r[pscp_pkg::SI_STAT];
    assign done_high = q_r[pscp_pkg::SI_DONE];
    assign ce_low = !q_r[pscp_pkg::SI_CE];
    assign uclk_rise = q_r[pscp_pkg::SI_UCLK] && !qd_r[pscp_pkg::SI_UCLK];
    assign byte_evt = q_r[pscp_pkg::SI_TGL] != qd_r[pscp_pkg::SI_TGL];
    assign loaded = q_r[pscp_pkg::SI_LOAD];
    assign fall_ok = q_r[pscp_pkg::SI_FALL];

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    pscp_pkg::pscp_state_e st_r;
    logic [pscp_pkg::CNT_W-1:0] cnt_r;
    logic err_r;
    logic init_tick;
    logic init_end;

    // user clock is only counted here, so it cannot disturb loading
    assign init_tick = user_clock_en ? uclk_rise : 1'b1;
    assign init_end = user_clock_en ?
        (cnt_r == pscp_pkg::CNT_W'(USR_INIT_CYC - 1)) :
        (cnt_r == pscp_pkg::CNT_W'(pscp_pkg::INIT_CYC - 1));

    // our own pull-down is still in the synchroniser when loading starts,
    // so a low status line counts only once it has been seen released
    logic stat_seen_r;

    always_ff @(posedge clk)
    begin
        if (!rst_n || !(st_r == pscp_pkg::ST_LOAD || st_r == pscp_pkg::ST_RELEASE))
            stat_seen_r <= 1'b0;
        else if (!stat_low)
            stat_seen_r <= 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            st_r <= pscp_pkg::ST_POR;
            cnt_r <= '0;
        end
        else if (req_low && st_r != pscp_pkg::ST_POR)
        begin
            st_r <= pscp_pkg::ST_RESET;
            cnt_r <= '0;
        end
        else
        begin
            unique case (st_r)
                pscp_pkg::ST_POR:
                begin
                    cnt_r <= cnt_r + 1'b1;
                    if (cnt_r == pscp_pkg::CNT_W'(POR_CYC - 1))
                    begin
                        st_r <= pscp_pkg::ST_LOAD;
                        cnt_r <= '0;
                    end
                end
                pscp_pkg::ST_RESET:
                begin
                    cnt_r <= cnt_r + 1'b1;
                    if (cnt_r == pscp_pkg::CNT_W'(pscp_pkg::STATUS_CYC - 1))
                    begin
                        st_r <= pscp_pkg::ST_LOAD;
                        cnt_r <= '0;
                    end
                end
                pscp_pkg::ST_LOAD:
                begin
                    if (err_r || (stat_seen_r && stat_low))
                        st_r <= pscp_pkg::ST_ERROR;
                    else if (loaded)
                        st_r <= pscp_pkg::ST_RELEASE;
                end
                pscp_pkg::ST_RELEASE:
                begin
                    // the wired line is high only once every device let go
                    if (err_r || (stat_seen_r && stat_low))
                        st_r <= pscp_pkg::ST_ERROR;
                    else if (done_high && fall_ok)
                        st_r <= pscp_pkg::ST_INIT;
                end
                pscp_pkg::ST_INIT:
                begin
                    if (init_tick)
                        cnt_r <= cnt_r + 1'b1;
                    if (init_tick && init_end)
                        st_r <= pscp_pkg::ST_USER;
                end
                pscp_pkg::ST_USER:
                    st_r <= pscp_pkg::ST_USER;
                pscp_pkg::ST_ERROR:
                    st_r <= pscp_pkg::ST_ERROR;
                default:
                    st_r <= pscp_pkg::ST_POR;
            endcase
        end
    end

    // ------------------------------------------------------------
    // serial domain control
    // ------------------------------------------------------------
    logic past_load;

    assign past_load = st_r == pscp_pkg::ST_RELEASE ||
        st_r == pscp_pkg::ST_INIT || st_r == pscp_pkg::ST_USER;

    // kept high past loading so the shifter keeps ignoring the clock;
    // registered so that no state decode glitch reaches the serial domain
    always_ff @(posedge clk)
    begin
        dn.load_en <= st_r == pscp_pkg::ST_LOAD || past_load;
        dn.done_high <= done_high && st_r == pscp_pkg::ST_RELEASE;
    end

    // ------------------------------------------------------------
    // byte pipe: rolling-key decrypt, then zero-run expansion
    // ------------------------------------------------------------
    logic [7:0] key_r;
    logic [6:0] run_r;
    logic [7:0] plain;
    logic take_byte;

    assign take_byte = byte_evt && st_r == pscp_pkg::ST_LOAD;
    assign plain = up.data ^ (decrypt_en ? key_r : 8'h00);

    always_ff @(posedge clk)
    begin
        if (!rst_n || st_r != pscp_pkg::ST_LOAD)
            key_r <= KEY;
        else if (take_byte)
            key_r <= {key_r[6:0], key_r[7] ^ key_r[5] ^ key_r[4] ^ key_r[3]};
    end

    // no buffer: a byte that lands while a run is still expanding is lost,
    // so it is flagged as an error rather than dropped silently
    always_ff @(posedge clk)
    begin
        if (!rst_n || st_r != pscp_pkg::ST_LOAD)
        begin
            run_r <= 7'h00;
            err_r <= 1'b0;
            config_byte <= 8'h00;
            config_byte_valid <= 1'b0;
        end
        else
        begin
            config_byte_valid <= 1'b0;
            if (take_byte && run_r != 7'h00)
                err_r <= 1'b1;
            else if (take_byte && decompress_en && plain[pscp_pkg::RUN_BIT])
            begin
                run_r <= plain[6:0];
            end
            else if (take_byte)
            begin
                config_byte <= plain;
                config_byte_valid <= 1'b1;
            end
            if (run_r != 7'h00 && !take_byte)
            begin
                run_r <= run_r - 7'h1;
                config_byte <= 8'h00;
                config_byte_valid <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // pins
    // ------------------------------------------------------------
    logic chain_r;
    logic chain_oe_r;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            chain_r <= 1'b1;
            chain_oe_r <= 1'b1;
        end
        else if (st_r == pscp_pkg::ST_USER && chain_pin_user)
        begin
            chain_r <= chain_user_data;
            chain_oe_r <= 1'b1;
        end
        else
        begin
            // stays high while this device is not enabled
            chain_r <= !(past_load && ce_low);
            chain_oe_r <= 1'b1;
        end
    end

    assign chain_enable_out_n = chain_r;
    assign chain_enable_out_n_oe = chain_oe_r;

    // both shared lines are only ever pulled low by this device
    assign status_open_drain_n_out = 1'b0;
    assign status_open_drain_n_oe = st_r == pscp_pkg::ST_POR ||
        st_r == pscp_pkg::ST_RESET || st_r == pscp_pkg::ST_ERROR;
    assign config_complete_line_out = 1'b0;
    assign config_complete_line_oe = !past_load;

    assign user_mode = st_r == pscp_pkg::ST_USER;
    assign config_error = st_r == pscp_pkg::ST_ERROR;

endmodule

// File: sim/pscp_top_sva.sv
/*
 * Port checker for the passive serial configuration port.
 * Assumes it is bound to pscp_top and sees only its ports.
 */
`timescale 1ns/10ps
module pscp_top_sva #(
    parameter int unsigned POR_CYC = 20
) (
    // core clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // request and shared lines
    input wire logic config_request_n,
    input wire logic status_open_drain_n_in,
    input wire logic status_open_drain_n_oe,
    input wire logic config_complete_line_in,
    input wire logic config_complete_line_oe,
    // chain pin and options
    input wire logic chain_enable_out_n,
    input wire logic chain_pin_user,
    input wire logic chain_user_data,
    // status outputs
    input wire logic config_byte_valid,
    input wire logic user_mode,
    input wire logic config_error
);
    // ------------------------------------------------------------
    // power-on cycle count
    // ------------------------------------------------------------
    logic [15:0] por_cnt_r;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            por_cnt_r <= 16'h0;
        else if (por_cnt_r != 16'hffff)
            por_cnt_r <= por_cnt_r + 16'h1;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    por_hold_a: assert property (por_cnt_r < POR_CYC - 1 |-> status_open_drain_n_oe)
        else $error("status released before power-on delay");
    chain_idle_a: assert property (config_complete_line_oe && $past(config_complete_line_oe)
        |-> chain_enable_out_n)
        else $error("chain enable low while loading");
    byte_load_a: assert property (config_byte_valid
        |-> !user_mode && !status_open_drain_n_oe)
        else $error("byte delivered outside loading");
    user_done_a: assert property (user_mode
        |-> !config_complete_line_oe && config_complete_line_in)
        else $error("user mode with done line low");
    err_stat_a: assert property (config_error
        |-> status_open_drain_n_oe && !user_mode)
        else $error("error without status pulled low");
    ext_stat_a: assert property ($fell(status_open_drain_n_in) && !status_open_drain_n_oe
        && config_complete_line_oe && config_request_n |-> ##[1:8] config_error)
        else $error("external status low not taken as error");
    req_restart_a: assert property (!config_request_n [*6]
        |-> status_open_drain_n_oe && config_complete_line_oe && !user_mode)
        else $error("request low did not restart");
    done_fall_a: assert property ($fell(config_complete_line_oe)
        |-> !config_error && !user_mode && !status_open_drain_n_oe)
        else $error("done line released out of order");
    user_chain_a: assert property (user_mode && $past(user_mode) && chain_pin_user
        && $stable(chain_user_data) |-> chain_enable_out_n == chain_user_data)
        else $error("chain pin not following user data");
endmodule

bind pscp_top pscp_top_sva #(.POR_CYC(POR_CYC)) i_sva (.clk, .rst_n, .config_request_n,
    .status_open_drain_n_in, .status_open_drain_n_oe, .config_complete_line_in,
    .config_complete_line_oe, .chain_enable_out_n, .chain_pin_user, .chain_user_data,
    .config_byte_valid, .user_mode, .config_error);

// File: sim/pscp_host.sv
/*
 * Behavioural configuration host driving the serial link and request.
 * Assumes the bench resolves the shared status wire and hands it in.
 */
`timescale 1ns/10ps
module pscp_host (
    // serial link
    output logic serial_config_clock,
    output logic serial_config_data_in,
    output logic chip_enable_in_n,
    // configuration request
    output logic config_request_n,
    // resolved status wire
    input wire logic status_n
);
    // ------------------------------------------------------------
    // link tasks
    // ------------------------------------------------------------
    initial
    begin
        serial_config_clock = 1'b0;
        serial_config_data_in = 1'b1;
        chip_enable_in_n = 1'b1;
        config_request_n = 1'b1;
    end

    task automatic set_ce(input logic v);
        chip_enable_in_n = v;
    endtask

    // clock stands low between bytes; data shows the inverse once released
    task automatic send_byte(input logic [7:0] b, output bit stopped);
        stopped = 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            if (!status_n)
                stopped = 1'b1;
            if (!stopped)
            begin
                serial_config_data_in = b[i];
                #40 serial_config_clock = 1'b1;
                #40 serial_config_clock = 1'b0;
            end
        end
        serial_config_data_in = ~b[7];
        #40;
    endtask

    task automatic pulses(input int n);
        repeat (n)
        begin
            serial_config_data_in = ~serial_config_data_in;
            #40 serial_config_clock = 1'b1;
            #40 serial_config_clock = 1'b0;
        end
    endtask

    // whole chain is restarted by one request pulse; the serial clock runs
    // meanwhile so the link sees its enable drop and clears
    task automatic request();
        config_request_n = 1'b0;
        pulses(8);
        config_request_n = 1'b1;
    endtask
endmodule

// File: sim/test_passive_serial_config_port.sv
/*
 * Self-checking bench for the passive serial configuration port.
 * Assumes the host model drives the link; open-drain wires resolve here.
 */
`timescale 1ns/10ps
module test_passive_serial_config_port;
    // ------------------------------------------------------------
    // wiring
    // ------------------------------------------------------------
    logic clk, rst_n, sclk, sdata, ce_n, req_n, tb_pull, uclk, ucken, cpu, cdata;
    logic stat_oe, stat_out, done_oe, done_out, chain_n, byte_v, umode, cerr, chain_oe, dcmp, dcry;
    logic [7:0] cbyte;
    logic [7:0] exp_q[$];
    int bad_count, n_compared, n;
    bit st;
    wire logic stat_w = !((stat_oe && !stat_out) || tb_pull);
    wire logic done_w = !(done_oe && !done_out);

    pscp_top #(.BYTES(4), .POR_CYC(20), .USR_INIT_CYC(16), .KEY(8'h5c)) i_dut (.clk(clk),
        .rst_n(rst_n),
        .serial_config_clock(sclk), .serial_config_data_in(sdata), .chip_enable_in_n(ce_n),
        .config_request_n(req_n), .status_open_drain_n_in(stat_w),
        .status_open_drain_n_out(stat_out), .status_open_drain_n_oe(stat_oe),
        .config_complete_line_in(done_w), .config_complete_line_out(done_out),
        .config_complete_line_oe(done_oe), .chain_enable_out_n(chain_n),
        .chain_enable_out_n_oe(chain_oe), .user_startup_clock(uclk), .user_clock_en(ucken),
        .decompress_en(dcmp), .decrypt_en(dcry), .chain_pin_user(cpu),
        .chain_user_data(cdata), .config_byte(cbyte), .config_byte_valid(byte_v),
        .user_mode(umode), .config_error(cerr));

    pscp_host i_host (.serial_config_clock(sclk), .serial_config_data_in(sdata),
        .chip_enable_in_n(ce_n), .config_request_n(req_n), .status_n(stat_w));

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial
    begin
        uclk = 1'b0;
        forever #50 uclk = ~uclk;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #2;
    endtask

    // bounded wait: 0 status free, 1 done free, 2 user mode, 3 error
    task automatic wait_on(input int sel, input int lim, output int cnt);
        logic c;
        c = 1'b0;
        cnt = 0;
        while (!c && cnt < lim)
        begin
            tick(1);
            cnt++;
            case (sel)
                0: c = (stat_oe === 1'b0);
                1: c = (done_oe === 1'b0);
                2: c = (umode === 1'b1);
                default: c = (cerr === 1'b1);
            endcase
        end
        if (!c)
        begin
            bad_count++;
            $display("[FAIL] wait %0d expected 1 seen 0", sel);
            wrap_up();
        end
    endtask

    // leading byte with enable high also lets the link enable settle
    task automatic start_load();
        wait_on(0, 1000, n);
        i_host.set_ce(1'b1);
        i_host.send_byte(8'ha5, st);
        chk("chain idle", 8'h1, chain_n);
        chk("chain oe", 8'h1, chain_oe);
        i_host.set_ce(1'b0);
    endtask

    task automatic load_image(output int cnt);
        logic [7:0] b;
        logic [7:0] k;
        k = 8'h5c;
        start_load();
        for (int i = 0; i < 4; i++)
        begin
            b = (i == 1) ? 8'h81 : 8'($urandom) & 8'h7f;
            exp_q.push_back((i == 1 && dcmp) ? 8'h00 : b);
            i_host.send_byte(dcry ? b ^ k : b, st);
            k = {k[6:0], k[7] ^ k[5] ^ k[4] ^ k[3]};
        end
        wait_on(1, 200, cnt);
        tick(8);
        chk("chain next", 8'h0, chain_n);
        chk("bytes left", 8'h0, 8'(exp_q.size()));
        i_host.pulses(3);
        wait_on(2, 3000, cnt);
    endtask

    // ------------------------------------------------------------
    // byte monitor and time limit
    // ------------------------------------------------------------
    always @(negedge clk)
    begin
        if (rst_n && byte_v === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk("spare byte", 8'h0, 8'h1);
            else
                chk("config byte", exp_q.pop_front(), cbyte);
        end
    end

    initial
    begin
        repeat (100000) @(posedge clk);
        bad_count++;
        $display("[FAIL] run time expected end seen limit");
        wrap_up();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        rst_n = 1'b0;
        tb_pull = 1'b0;
        ucken = 1'b0;
        cpu = 1'b1;
        cdata = 1'b0;
        dcmp = 1'b1;
        dcry = 1'b0;
        bad_count = 0;
        n_compared = 0;
        void'($urandom(32'h9c4f));
        repeat (2) @(posedge clk);
        #2 rst_n = 1'b1;
        chk("status held", 8'h1, stat_oe);
        i_host.pulses(3);
        cdata = 1'($urandom);
        load_image(n);
        chk("init long", 8'h1, 8'(n > 2100));
        tick(2);
        chk("chain user", 8'(cdata), 8'(chain_n));
        i_host.send_byte(8'h3c, st);
        i_host.pulses(4);
        chk("user kept", 8'h1, umode);
        i_host.request();
        tick(6);
        chk("restart", 8'h0, umode);
        chk("done held", 8'h1, done_oe);
        ucken = 1'b1;
        cpu = 1'b0;
        dcmp = 1'b0;
        dcry = 1'b1;
        load_image(n);
        chk("init short", 8'h1, 8'(n < 200));
        chk("chain low", 8'h0, chain_n);
        dcry = 1'b0;
        i_host.request();
        start_load();
        exp_q.push_back(8'h2d);
        i_host.send_byte(8'h2d, st);
        tick(10);
        tb_pull = 1'b1;
        wait_on(3, 20, n);
        tb_pull = 1'b0;
        tick(10);
        chk("error held", 8'h1, stat_oe);
        i_host.request();
        tick(8);
        chk("error cleared", 8'h0, cerr);
        wrap_up();
    end
endmodule
